// ===== hw/hcb_ctrl.sv
// Bring-up and command controller that drives a host controller's registers.
// Assumes software on a classic Wishbone slave port and the device's register
// port on a Wishbone master port, all on one 40 MHz clock.
//
// Overview of operation
// [RL1] One command ring: every command goes through doorbell zero.
// [RL2] Commands are placed on the ring, then doorbell zero gets the command code.
// [RL3] Device posts a completion event for each executed command.
// [RL4] Device holds not-ready after reset; no register writes until it reads zero.
// [RL5] All setup writes finish before run/stop is written one.
// [RL6] Enabled slot count is written exactly as software requests.
// [RL7] Context array pointer is a 64-bit host address.
// [RL8] Command ring register takes the 64-bit first block address.
// [RL9] Message vector entry zero is set up before starting, if used.
// [RL10] Segment table entries give address and size; table size register gets count.
// [RL11] Event dequeue pointer gets the first segment's start address.
// [RL12] Writing the segment table base enables the event ring; written last.
// [RL13] Moderation interval is set before interrupts are enabled.
// [RL14] Device raises bus interrupts only while interrupter-enable is one.
// [RL15] An interrupter signals only after its enable field is written one.
// [RL16] Doorbells are accepted only once run/stop is one.
// [RL17] Slower ports enable only through port reset, then send frame markers.
// [RL18] Fastest ports enable on their own after a good attach.
// [RL19] Interrupts optional; controller can be run by polling event rings.
// [RL20] Ring blocks are processed in order; appending needs no locking.
// [RL21] Short packets and split transactions are handled without software.
// [RL22] Bandwidth query returns free periodic bandwidth for every root port.
`timescale 1ns/1ps
`default_nettype none
module hcb_ctrl import hcb_pkg::*; (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [SW_AW-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [DW-1:0] wbDatI,
    output logic [DW-1:0] wbDatO,
    output logic wbAck,
    output logic devCyc,
    output logic devStb,
    output logic devWe,
    output logic [DEV_AW-1:0] devAdr,
    output logic [3:0] devSel,
    output logic [DW-1:0] devDatO,
    input wire logic [DW-1:0] devDatI,
    input wire logic devAck,
    output logic running
);
    logic [DW-1:0] cfgW [0:CFG_NUM-1];
    logic swHit;
    logic swWr;
    logic cfgHit;
    logic [DW-1:0] rdD;
    logic irqUseQ;
    logic startQ;
    logic refusedQ;
    logic dbPendQ;
    logic [DB_W-1:0] dbCodeQ;
    logic [DW-1:0] cmdCntQ;
    logic readySeenQ;
    logic runningQ;
    logic [3:0] stepQ;
    hcb_seq_t seqQ;
    logic mStart;
    logic mBusy;
    logic mDone;
    logic [DW-1:0] mRd;
    logic reqWe;
    logic [DEV_AW-1:0] reqAdr;
    logic [DW-1:0] reqDat;
    logic dbReq;
    logic dbAccept;
    logic refuseClr;
    logic modWrittenQ;
    logic segbWrittenQ;
    logic devWrAck;

    // ==========================================
    // Software port decode
    assign swHit = wbCyc && wbStb && !wbAck;
    assign swWr = swHit && wbWe;
    assign cfgHit = (wbAdr < SW_CFG_END) && (wbAdr[1:0] == 2'b00);

    // ==========================================
    // Setup words, one byte lane per generate pass
    for (genvar l = 0; l < 4; l++) begin : genLane
        logic [7:0] byteQ [0:CFG_NUM-1];
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                for (int i = 0; i < CFG_NUM; i++) begin
                    byteQ[i] <= 8'h00;
                end
            end else if (swWr && cfgHit && wbSel[l]) begin
                byteQ[wbAdr[5:2]] <= wbDatI[l*8 +: 8];
            end
        end
        for (genvar i = 0; i < CFG_NUM; i++) begin : genWord
            assign cfgW[i][l*8 +: 8] = byteQ[i];
        end
    end

    // ==========================================
    // Control register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqUseQ <= 1'b0;
            startQ <= 1'b0;
        end else begin
            startQ <= 1'b0;
            if (swWr && wbAdr == SW_CTRL && wbSel[0]) begin
                startQ <= wbDatI[CTRL_START];
                irqUseQ <= wbDatI[CTRL_IRQ]; // see [RL19]
            end
        end
    end

    // ==========================================
    // Doorbell request from software
    assign dbReq = swWr && wbAdr == SW_DOORBELL && wbSel[0];
    assign dbAccept = dbReq && runningQ && !dbPendQ; // see [RL16]
    assign refuseClr = swWr && wbAdr == SW_STATUS && wbSel[0] && wbDatI[STS_REFUSED];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dbPendQ <= 1'b0;
            dbCodeQ <= '0;
        end else if (dbAccept) begin
            dbPendQ <= 1'b1;
            dbCodeQ <= wbDatI[DB_W-1:0];
        end else if (mDone && seqQ == SEQ_RUN) begin
            dbPendQ <= 1'b0;
        end
    end

    // Refusal flag: a new refusal wins over a clear in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            refusedQ <= 1'b0;
        end else if (dbReq && !dbAccept) begin
            refusedQ <= 1'b1;
        end else if (refuseClr) begin
            refusedQ <= 1'b0;
        end
    end

    // Doorbells delivered, one completion event expected for each
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmdCntQ <= '0;
        end else if (mDone && seqQ == SEQ_RUN) begin
            cmdCntQ <= cmdCntQ + 32'h0000_0001; // see [RL3]
        end
    end

    // ==========================================
    // Software read path
    always_comb begin
        rdD = '0;
        if (cfgHit) begin
            rdD = cfgW[wbAdr[5:2]];
        end else if (wbAdr == SW_CTRL) begin
            rdD[CTRL_IRQ] = irqUseQ;
        end else if (wbAdr == SW_STATUS) begin
            rdD[STS_READY] = readySeenQ;
            rdD[STS_RUN] = runningQ;
            rdD[STS_PEND] = dbPendQ;
            rdD[STS_REFUSED] = refusedQ;
        end else if (wbAdr == SW_CMD_COUNT) begin
            rdD = cmdCntQ;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wbAck <= 1'b0;
            wbDatO <= '0;
        end else begin
            wbAck <= swHit;
            if (swHit && !wbWe) begin
                wbDatO <= rdD;
            end
        end
    end

    // ==========================================
    // Bring-up sequencer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            seqQ <= SEQ_IDLE;
            stepQ <= '0;
            readySeenQ <= 1'b0;
            runningQ <= 1'b0;
        end else begin
            unique case (seqQ)
                SEQ_IDLE: begin
                    if (startQ) begin
                        seqQ <= SEQ_POLL;
                    end
                end
                SEQ_POLL: begin
                    if (mDone && !mRd[DEV_NRDY_BIT]) begin // see [RL4]
                        readySeenQ <= 1'b1;
                        stepQ <= '0;
                        seqQ <= SEQ_SETUP;
                    end
                end
                SEQ_SETUP: begin
                    if (mDone) begin
                        if (stepQ == STEP_LAST) begin // see [RL5]
                            runningQ <= 1'b1;
                            seqQ <= SEQ_RUN;
                        end else begin
                            stepQ <= stepQ + 4'h1;
                        end
                    end
                end
                SEQ_RUN: begin
                end
            endcase
        end
    end

    assign running = runningQ;

    // Words go out in table order: slots, context, ring, event regs, base last
    always_comb begin
        reqWe = 1'b0;
        reqAdr = DEV_STS;
        reqDat = '0;
        unique case (seqQ)
            SEQ_IDLE, SEQ_POLL: begin
            end
            SEQ_SETUP: begin
                reqWe = 1'b1;
                if (stepQ < STEP_IMAN) begin
                    // see [RL6] [RL7] [RL8] [RL10] [RL11] [RL12] [RL13]
                    reqAdr = cfgDevAdr(stepQ);
                    reqDat = cfgW[stepQ];
                end else if (stepQ == STEP_IMAN) begin
                    reqAdr = DEV_IMAN;
                    reqDat[DEV_IRQEN_BIT] = irqUseQ; // see [RL15]
                end else begin
                    reqAdr = DEV_CMD;
                    reqDat[DEV_BUSIRQ_BIT] = irqUseQ; // see [RL14]
                    reqDat[DEV_RUN_BIT] = (stepQ == STEP_LAST);
                end
            end
            SEQ_RUN: begin
                reqWe = 1'b1;
                reqAdr = DEV_DB0; // see [RL1]
                reqDat[DB_W-1:0] = dbCodeQ; // see [RL2]
            end
        endcase
    end

    // Message vectors are set up by software before the start bit; see [RL9]
    assign mStart = !mBusy && (seqQ == SEQ_POLL || seqQ == SEQ_SETUP || (seqQ == SEQ_RUN && dbPendQ));

    hcb_wb_master uMaster (
        .clock(clock),
        .reset_n(reset_n),
        .reqStart(mStart),
        .reqWe(reqWe),
        .reqAdr(reqAdr),
        .reqDat(reqDat),
        .busy(mBusy),
        .done(mDone),
        .rdData(mRd),
        .mCyc(devCyc),
        .mStb(devStb),
        .mWe(devWe),
        .mAdr(devAdr),
        .mSel(devSel),
        .mDatO(devDatO),
        .mDatI(devDatI),
        .mAck(devAck)
    );

    // ==========================================
    // Checks
    assign devWrAck = devCyc && devStb && devWe && devAck;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            modWrittenQ <= 1'b0;
            segbWrittenQ <= 1'b0;
        end else begin
            if (devWrAck && devAdr == cfgDevAdr(CFG_MODERATE)) begin
                modWrittenQ <= 1'b1;
            end
            if (devWrAck && devAdr == cfgDevAdr(CFG_SEGB_HI)) begin
                segbWrittenQ <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_ready_before_write: assert property (devCyc && devWe |-> readySeenQ) // see [RL4]
        else $error("device written before ready");
    a_run_after_setup: assert property ( // see [RL5]
        devCyc && devWe && devAdr == DEV_CMD && devDatO[DEV_RUN_BIT] |-> segbWrittenQ && stepQ == STEP_LAST)
        else $error("run set before setup done");
    a_slot_count: assert property ( // see [RL6]
        devCyc && devWe && devAdr == cfgDevAdr(CFG_SLOTS) |-> devDatO == cfgW[CFG_SLOTS])
        else $error("slot count differs");
    a_ctx_pointer_pair: assert property ( // see [RL7]
        devWrAck && devAdr == cfgDevAdr(CFG_CTX_LO)
        |=> ##[1:8] devCyc && devAdr == cfgDevAdr(CFG_CTX_HI) && devDatO == cfgW[CFG_CTX_HI])
        else $error("context pointer upper word missing");
    a_ring_pointer: assert property ( // see [RL8]
        devCyc && devWe && devAdr == cfgDevAdr(CFG_CRING_LO) |-> devDatO == cfgW[CFG_CRING_LO])
        else $error("command ring pointer differs");
    a_dequeue_value: assert property ( // see [RL11]
        devWrAck && devAdr == cfgDevAdr(CFG_DEQ_LO) |-> devDatO == cfgW[CFG_DEQ_LO] && stepQ == CFG_DEQ_LO)
        else $error("dequeue pointer wrong");
    a_segbase_last: assert property ( // see [RL12]
        devCyc && devWe && (devAdr == cfgDevAdr(CFG_SEG_SIZE) || devAdr == cfgDevAdr(CFG_DEQ_LO)
        || devAdr == cfgDevAdr(CFG_MODERATE)) |-> !segbWrittenQ)
        else $error("event register after segment base");
    a_mod_before_ie: assert property (devCyc && devWe && devAdr == DEV_IMAN |-> modWrittenQ) // see [RL13]
        else $error("interrupter enabled before moderation");
    a_doorbell_target: assert property ( // see [RL2]
        devCyc && devWe && devAdr == DEV_DB0 |-> runningQ && devDatO[DB_W-1:0] == dbCodeQ)
        else $error("doorbell target wrong");
    a_doorbell_served: assert property ( // see [RL16]
        dbAccept |=> dbPendQ ##[1:40] !dbPendQ)
        else $error("accepted doorbell not delivered");
    a_sw_ack_pulse: assert property (wbAck |=> !wbAck)
        else $error("software ack longer than one cycle");
endmodule
`default_nettype wire

// ===== common/hcb_pkg.sv
// Shared constants and types of the bring-up and command controller.
// Assumes one 40 MHz clock shared with the controlled device's register port.
package hcb_pkg;

    // ==========================================
    // Widths
    localparam int SW_AW = 8;
    localparam int DEV_AW = 16;
    localparam int DW = 32;
    localparam int DB_W = 8;
    localparam int CFG_NUM = 11;

    // ==========================================
    // Software register map
    localparam logic [3:0] CFG_SLOTS = 4'h0;
    localparam logic [3:0] CFG_CTX_LO = 4'h1;
    localparam logic [3:0] CFG_CTX_HI = 4'h2;
    localparam logic [3:0] CFG_CRING_LO = 4'h3;
    localparam logic [3:0] CFG_CRING_HI = 4'h4;
    localparam logic [3:0] CFG_SEG_SIZE = 4'h5;
    localparam logic [3:0] CFG_DEQ_LO = 4'h6;
    localparam logic [3:0] CFG_DEQ_HI = 4'h7;
    localparam logic [3:0] CFG_MODERATE = 4'h8;
    localparam logic [3:0] CFG_SEGB_LO = 4'h9;
    localparam logic [3:0] CFG_SEGB_HI = 4'ha;
    localparam logic [7:0] SW_CFG_END = 8'h2c;
    localparam logic [7:0] SW_CTRL = 8'h30;
    localparam logic [7:0] SW_STATUS = 8'h34;
    localparam logic [7:0] SW_DOORBELL = 8'h38;
    localparam logic [7:0] SW_CMD_COUNT = 8'h3c;
    localparam int CTRL_START = 0;
    localparam int CTRL_IRQ = 1;
    localparam int STS_READY = 0;
    localparam int STS_RUN = 1;
    localparam int STS_PEND = 2;
    localparam int STS_REFUSED = 3;

    // ==========================================
    // Device register map and fields
    localparam logic [15:0] DEV_CMD = 16'h0000;
    localparam logic [15:0] DEV_STS = 16'h0004;
    localparam logic [15:0] DEV_CFG_BASE = 16'h0020;
    localparam logic [15:0] DEV_IMAN = 16'h0060;
    localparam logic [15:0] DEV_DB0 = 16'h0080;
    localparam int DEV_RUN_BIT = 0;
    localparam int DEV_IRQEN_BIT = 1;
    localparam int DEV_BUSIRQ_BIT = 2;
    localparam int DEV_NRDY_BIT = 11;
    localparam logic [3:0] SEL_ALL = 4'hf;

    // ==========================================
    // Setup steps after the pointer copies
    localparam logic [3:0] STEP_IMAN = 4'hb;
    localparam logic [3:0] STEP_LAST = 4'hd;

    typedef enum {BUS_IDLE, BUS_ACTIVE, BUS_GAP} hcb_bus_t;
    typedef enum {SEQ_IDLE, SEQ_POLL, SEQ_SETUP, SEQ_RUN} hcb_seq_t;

    // Device address of a copied setup word
    function automatic logic [15:0] cfgDevAdr(input logic [3:0] idx);
        return DEV_CFG_BASE + {10'h000, idx, 2'b00};
    endfunction

endpackage

// ===== hw/hcb_wb_master.sv
// Single-access classic Wishbone master toward the device registers.
// Assumes the device answers on the same clock; one access at a time.
`timescale 1ns/1ps
`default_nettype none
module hcb_wb_master import hcb_pkg::*; (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reqStart,
    input wire logic reqWe,
    input wire logic [DEV_AW-1:0] reqAdr,
    input wire logic [DW-1:0] reqDat,
    output logic busy,
    output logic done,
    output logic [DW-1:0] rdData,
    output logic mCyc,
    output logic mStb,
    output logic mWe,
    output logic [DEV_AW-1:0] mAdr,
    output logic [3:0] mSel,
    output logic [DW-1:0] mDatO,
    input wire logic [DW-1:0] mDatI,
    input wire logic mAck
);
    hcb_bus_t busQ;

    // ==========================================
    // Bus cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busQ <= BUS_IDLE;
            mCyc <= 1'b0;
            mStb <= 1'b0;
            mWe <= 1'b0;
            mAdr <= '0;
            mSel <= '0;
            mDatO <= '0;
            done <= 1'b0;
            rdData <= '0;
        end else begin
            done <= 1'b0;
            unique case (busQ)
                BUS_IDLE: begin
                    if (reqStart) begin
                        busQ <= BUS_ACTIVE;
                        mCyc <= 1'b1;
                        mStb <= 1'b1;
                        mWe <= reqWe;
                        mAdr <= reqAdr;
                        mSel <= SEL_ALL;
                        mDatO <= reqDat;
                    end
                end
                BUS_ACTIVE: begin
                    if (mAck) begin
                        busQ <= BUS_GAP;
                        mCyc <= 1'b0;
                        mStb <= 1'b0;
                        done <= 1'b1;
                        rdData <= mDatI;
                    end
                end
                BUS_GAP: busQ <= BUS_IDLE;
            endcase
        end
    end

    assign busy = (busQ != BUS_IDLE);

    // ==========================================
    // Checks
    a_req_held: assert property (@(posedge clock) disable iff (!reset_n)
        mCyc && !mAck |=> mCyc && $stable(mAdr) && $stable(mWe) && $stable(mDatO))
        else $error("request changed before ack");
    a_gap_after_ack: assert property (@(posedge clock) disable iff (!reset_n)
        mCyc && mAck |=> !mCyc && done ##1 !mCyc)
        else $error("no idle cycle after ack");
endmodule
`default_nettype wire

// ===== verif/hcb_dev_model.sv
// Behavioural model of the controlled host controller's register port.
// Assumes the classic Wishbone master of hcb_ctrl on the same clock; answer delay set by the bench.
`timescale 1ns/1ps
`default_nettype none
module hcb_dev_model import hcb_pkg::*; #(
    parameter int NRDY_READS = 3
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic devCyc,
    input wire logic devStb,
    input wire logic devWe,
    input wire logic [DEV_AW-1:0] devAdr,
    input wire logic [3:0] devSel,
    input wire logic [DW-1:0] devDatO,
    output logic [DW-1:0] devDatI,
    output logic devAck,
    input wire logic [3:0] delay,
    output logic irqOut
);
    // ==========================================
    // State
    logic [3:0] waitQ;
    logic [31:0] cmdQ;
    logic [31:0] imanQ;
    logic [63:0] ctxQ;
    logic [63:0] ringQ;
    logic ringOn;
    logic [7:0] dbLast;
    int polls;
    int doneCount;
    int earlyWrites;
    int badDb;
    int logN;
    logic [15:0] logAdr [0:31];
    logic [31:0] logDat [0:31];
    logic notReady;

    assign notReady = (polls < NRDY_READS);
    // Bus interrupt only with both enables and a live event ring
    assign irqOut = cmdQ[DEV_BUSIRQ_BIT] & imanQ[DEV_IRQEN_BIT] & ringOn & (doneCount != 0);

    // ==========================================
    // Register port
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            waitQ <= 4'h0;
            cmdQ <= 32'h0;
            imanQ <= 32'h0;
            ctxQ <= 64'h0;
            ringQ <= 64'h0;
            ringOn <= 1'b0;
            dbLast <= 8'h00;
            polls <= 0;
            doneCount <= 0;
            earlyWrites <= 0;
            badDb <= 0;
            logN <= 0;
            devAck <= 1'b0;
            devDatI <= 32'h5a5a5a5a;
        end else begin
            devAck <= 1'b0;
            // Released data lines never hold the last value
            devDatI <= ~devDatI;
            if (devCyc && devStb && !devAck) begin
                if (waitQ < delay) begin
                    waitQ <= waitQ + 4'h1;
                end else begin
                    waitQ <= 4'h0;
                    devAck <= 1'b1;
                    if (!devWe) begin
                        if (devAdr == DEV_STS) begin
                            devDatI <= {20'h0, notReady, 11'h0};
                            if (notReady) polls <= polls + 1;
                        end else begin
                            devDatI <= (devAdr == DEV_CMD) ? cmdQ : 32'h0;
                        end
                    end else begin
                        if (notReady) earlyWrites <= earlyWrites + 1;
                        if (logN < 32) begin
                            logAdr[logN] <= devAdr;
                            logDat[logN] <= devDatO;
                            logN <= logN + 1;
                        end
                        case (devAdr)
                            DEV_CMD: cmdQ <= devDatO;
                            DEV_IMAN: imanQ <= devDatO;
                            16'h0024: ctxQ[31:0] <= devDatO;
                            16'h0028: ctxQ[63:32] <= devDatO;
                            16'h002c: ringQ[31:0] <= devDatO;
                            16'h0030: ringQ[63:32] <= devDatO;
                            16'h0048: ringOn <= 1'b1;
                            DEV_DB0: begin
                                // One command ring behind doorbell zero, open only while running
                                if (cmdQ[DEV_RUN_BIT]) begin
                                    dbLast <= devDatO[7:0];
                                    doneCount <= doneCount + 1;
                                end else begin
                                    badDb <= badDb + 1;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/test_hcb_ctrl.sv
// Self-checking bench of hcb_ctrl: software accesses over classic Wishbone.
// Assumes hcb_dev_model on the device port; 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_hcb_ctrl;
    import hcb_pkg::*;
    logic clock, reset_n, wbCyc, wbStb, wbWe, wbAck, devCyc, devStb, devWe, devAck, running, irqOut;
    logic [7:0] wbAdr;
    logic [3:0] wbSel, devSel, delay;
    logic [31:0] wbDatI, wbDatO, devDatO, devDatI, rd;
    logic [15:0] devAdr;
    int failures, nCompared, cycles, i, base;
    logic [7:0] codes [0:2];

    hcb_ctrl dut (.clock(clock), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .devCyc(devCyc),
        .devStb(devStb), .devWe(devWe), .devAdr(devAdr), .devSel(devSel), .devDatO(devDatO),
        .devDatI(devDatI), .devAck(devAck), .running(running));
    hcb_dev_model #(.NRDY_READS(3)) dev (.clock(clock), .reset_n(reset_n), .devCyc(devCyc),
        .devStb(devStb), .devWe(devWe), .devAdr(devAdr), .devSel(devSel), .devDatO(devDatO),
        .devDatI(devDatI), .devAck(devAck), .delay(delay), .irqOut(irqOut));

    // ==========================================
    // Clock, timeout and checks
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles > 30000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d, mismatched %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // ==========================================
    // Software bus access, held until the ack edge
    task automatic wbAccess(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        wbSel <= SEL_ALL;
        do @(posedge clock);
        while (wbAck !== 1'b1);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic expectReg(input logic [7:0] a, input logic [31:0] exp);
        wbAccess(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Poll status until the masked bits match; a hang ends at the run's timeout
    task automatic waitStatus(input logic [31:0] mask, input logic [31:0] val);
        do wbAccess(1'b0, SW_STATUS, 32'h0);
        while ((rd & mask) !== val);
    endtask

    task automatic doReset();
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
    endtask

    // Setup words, start, then the device write log in order
    task automatic bringUp(input logic irq);
        for (int k = 0; k < 11; k++) wbAccess(1'b1, 8'(k * 4), 32'h5a000000 + k);
        wbAccess(1'b1, SW_CTRL, {30'h0, irq, 1'b1});
        waitStatus(32'h2, 32'h2);
        check(32'(dev.logN), 32'd14);
        for (int k = 0; k < 11; k++) begin
            check({16'h0, dev.logAdr[k]}, 32'h20 + 32'(k * 4));
            check(dev.logDat[k], 32'h5a000000 + k);
        end
        check({16'h0, dev.logAdr[11]}, 32'h60);
        check(dev.logDat[11], {30'h0, irq, 1'b0});
        check({16'h0, dev.logAdr[12]}, 32'h0);
        check(dev.logDat[12], {29'h0, irq, 2'b00});
        check({16'h0, dev.logAdr[13]}, 32'h0);
        check(dev.logDat[13], {29'h0, irq, 2'b01});
        check(32'(dev.earlyWrites), 32'h0);
        check(32'(dev.polls), 32'd3);
        check(dev.ctxQ[63:32], 32'h5a000002);
        check(dev.ringQ[63:32], 32'h5a000004);
        check(dev.ringQ[31:0], 32'h5a000003);
        check({31'h0, dev.ringOn}, 32'h1);
        check({28'h0, devSel}, 32'hf);
        check({31'h0, running}, 32'h1);
        expectReg(SW_STATUS, 32'h3);
    endtask

    // ==========================================
    // Scenarios
    initial begin
        reset_n = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatI = 32'h0;
        delay = 4'h0;
        failures = 0;
        nCompared = 0;
        cycles = 0;
        codes[0] = 8'h01;
        codes[1] = 8'h17;
        codes[2] = 8'hff;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        expectReg(SW_STATUS, 32'h0);
        expectReg(SW_CMD_COUNT, 32'h0);
        wbAccess(1'b1, 8'hfc, 32'hffffffff);
        expectReg(8'hfc, 32'h0);
        // Doorbell before running is refused and never reaches the device
        wbAccess(1'b1, SW_DOORBELL, 32'h05);
        expectReg(SW_STATUS, 32'h8);
        check(32'(dev.logN), 32'h0);
        wbAccess(1'b1, SW_STATUS, 32'h8);
        expectReg(SW_STATUS, 32'h0);
        delay <= 4'h2;
        bringUp(1'b1);
        for (i = 0; i < 3; i++) begin
            wbAccess(1'b1, SW_DOORBELL, {24'h0, codes[i]});
            waitStatus(32'h4, 32'h0);
            check({24'h0, dev.dbLast}, {24'h0, codes[i]});
            check({16'h0, dev.logAdr[14 + i]}, 32'h80);
            expectReg(SW_CMD_COUNT, 32'(i + 1));
            check(32'(dev.doneCount), 32'(i + 1));
        end
        check({31'h0, irqOut}, 32'h1);
        // Back-to-back doorbells against a slow device: the second is refused
        delay <= 4'h8;
        wbAccess(1'b1, SW_DOORBELL, 32'h21);
        wbAccess(1'b1, SW_DOORBELL, 32'h22);
        waitStatus(32'h4, 32'h0);
        expectReg(SW_STATUS, 32'hb);
        expectReg(SW_CMD_COUNT, 32'd4);
        check({24'h0, dev.dbLast}, 32'h21);
        wbAccess(1'b1, SW_STATUS, 32'h8);
        expectReg(SW_STATUS, 32'h3);
        // Start while running changes nothing at the device
        base = dev.logN;
        wbAccess(1'b1, SW_CTRL, 32'h1);
        repeat (3) wbAccess(1'b0, SW_STATUS, 32'h0);
        check(32'(dev.logN), 32'(base));
        // Second chip reset mid-run, polled operation without interrupts
        delay <= 4'h3;
        doReset();
        check({31'h0, running}, 32'h0);
        expectReg(SW_STATUS, 32'h0);
        bringUp(1'b0);
        wbAccess(1'b1, SW_DOORBELL, 32'h3c);
        waitStatus(32'h4, 32'h0);
        check(32'(dev.doneCount), 32'h1);
        check({31'h0, irqOut}, 32'h0);
        check(32'(dev.badDb), 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
